// *** src/pond_pkg.sv ***
/*
  Constants and types for the pattern output next-data register bank.
  Assumes an AHB-Lite slave with 32-bit data and single word transfers.
*/
package pond_pkg;

  // ----------------------------------------------------------------
  // Register indices as printed; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_NEXT_HIGH_PRIMARY = 32'h05ff_fff4;
  localparam logic [31:0] IDX_NEXT_LOW_PRIMARY = 32'h05ff_fff5;
  localparam logic [31:0] IDX_NEXT_HIGH_SECONDARY = 32'h05ff_fff6;
  localparam logic [31:0] IDX_NEXT_LOW_SECONDARY = 32'h05ff_fff7;

  // ----------------------------------------------------------------
  // Byte addresses of the remaining registers
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_PORT_MODE_UPPER = 32'h0000_0000;
  localparam logic [31:0] ADDR_PORT_MODE_LOWER = 32'h0000_0004;
  localparam logic [31:0] ADDR_PORT_OUTPUT_DATA = 32'h0000_0008;
  localparam logic [31:0] ADDR_OUTPUT_ENABLE = 32'h0000_000c;
  localparam logic [31:0] ADDR_TRIGGER_SELECT = 32'h0000_0010;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PORT_MODE = 16'h0000;
  localparam logic [15:0] RST_PORT_DATA = 16'h0000;
  localparam logic [15:0] RST_OUTPUT_ENABLE = 16'h0000;
  localparam logic [7:0] RST_NEXT_DATA = 8'h00;
  localparam logic [7:0] RST_TRIGGER_SELECT = 8'hff;
  localparam logic [7:0] RESERVED_BYTE = 8'hff;
  localparam logic [3:0] RESERVED_NIBBLE = 4'hf;
  localparam int GROUP_W = 4;
  localparam int SEL_W = 2;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  // ----------------------------------------------------------------
  // Latched address phase
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
  } pond_aphase_s;

endpackage : pond_pkg

// *** src/pond_regs.sv ***
/*
  Register bank of a 16-bit timed pattern output unit: port mode,
  port data, per-bit enables, trigger select and two next-data registers.
  Assumes a zero-wait AHB-Lite master and one-cycle compare-match pulses
  from the timer pulse unit.
*/
`timescale 1ns/1ps

// Behaviour
// - Two 16-bit read/write port mode registers, two bits per pin, reset zero.
// - 16-bit port data register drives pattern pins 15..0, resets to zero.
// - Port data bits with pattern enable set ignore processor writes.
// - Low next-data byte copies into port data 7..0 on selected match.
// - High next-data byte copies into port data 15..8 on selected match.
// - Low next-data resets to zero, kept through standby.
// - High next-data resets to zero, kept through standby.
// - Shared trigger groups 1,0: whole low byte at primary address.
// - Shared trigger groups 1,0: secondary address reads all ones, unwritable.
// - Split triggers groups 1,0: group 1 at primary, group 0 at secondary.
// - Split triggers groups 1,0: unused nibbles read as ones.
// - Shared trigger groups 3,2: whole high byte at primary address.
// - Shared trigger groups 3,2: secondary address reads all ones.
// - Split triggers groups 3,2: group 3 at primary, group 2 at secondary.
// - Split triggers groups 3,2: unused nibbles read as ones.
// - Copy only touches enabled bits; disabled bits keep their value.
// - Two-bit select per group picks channel 0..3; resets to channel 3.
module pond_regs
  import pond_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] cmp_match,
  output logic [15:0] pattern_out_pins,
  output logic [15:0] port_mode_upper_pins,
  output logic [15:0] port_mode_lower_pins
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Readback of a next-data byte at its primary or secondary address
  function automatic logic [7:0] nd_read(input logic [7:0] nd, input logic same,
                                         input logic secondary);
    logic [7:0] r;
    r = RESERVED_BYTE;
    if (!secondary)
      r = same ? nd : {nd[7:4], RESERVED_NIBBLE};
    else if (!same)
      r = {RESERVED_NIBBLE, nd[3:0]};
    return r;
  endfunction : nd_read

  // Writable bits of a next-data byte at its primary or secondary address
  function automatic logic [7:0] nd_wmask(input logic same, input logic secondary);
    logic [7:0] m;
    m = 8'h00;
    if (!secondary)
      m = same ? 8'hff : 8'hf0;
    else if (!same)
      m = 8'h0f;
    return m;
  endfunction : nd_wmask

  function automatic logic [31:0] idx_addr(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction : idx_addr

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pond_aphase_s ap_ff;
  logic [31:0] hrdata_ff;
  logic [15:0] mode_upper_ff;
  logic [15:0] mode_lower_ff;
  logic [15:0] port_data_ff;
  logic [15:0] enable_ff;
  logic [7:0] trig_sel_ff;
  logic [7:0] next_low_ff;
  logic [7:0] next_high_ff;
  logic [31:0] nxt_hrdata;
  logic [3:0] group_fire;
  logic [15:0] copy_mask;
  logic [7:0] low_wmask;
  logic [7:0] high_wmask;
  logic hreadyout_ff;
  logic hresp_ff;
  logic same_low;
  logic same_high;
  logic take;
  logic wr_mode_upper;
  logic wr_mode_lower;
  logic wr_port_data;
  logic wr_enable;
  logic wr_trig_sel;
  logic wr_low_pri;
  logic wr_low_sec;
  logic wr_high_pri;
  logic wr_high_sec;

  // ----------------------------------------------------------------
  // Trigger selection and layout
  // ----------------------------------------------------------------
  assign same_low = (trig_sel_ff[1:0] == trig_sel_ff[3:2]);
  assign same_high = (trig_sel_ff[5:4] == trig_sel_ff[7:6]);
  assign low_wmask = nd_wmask(same_low, wr_low_sec);
  assign high_wmask = nd_wmask(same_high, wr_high_sec);

  always_comb
  begin
    for (int g = 0; g < 4; g++)
    begin
      group_fire[g] = cmp_match[trig_sel_ff[g*SEL_W +: SEL_W]];
      copy_mask[g*GROUP_W +: GROUP_W] = {GROUP_W{group_fire[g]}}
                                        & enable_ff[g*GROUP_W +: GROUP_W];
    end
  end

  // ----------------------------------------------------------------
  // Bus address phase and read data
  // ----------------------------------------------------------------
  assign take = hsel && hready && htrans[1];

  always_comb
  begin
    nxt_hrdata = 32'h0000_0000;
    case (haddr)
      ADDR_PORT_MODE_UPPER: nxt_hrdata = {16'h0000, mode_upper_ff};
      ADDR_PORT_MODE_LOWER: nxt_hrdata = {16'h0000, mode_lower_ff};
      ADDR_PORT_OUTPUT_DATA: nxt_hrdata = {16'h0000, port_data_ff};
      ADDR_OUTPUT_ENABLE: nxt_hrdata = {16'h0000, enable_ff};
      ADDR_TRIGGER_SELECT: nxt_hrdata = {24'h00_0000, trig_sel_ff};
      idx_addr(IDX_NEXT_LOW_PRIMARY):
        nxt_hrdata = {24'h00_0000, nd_read(next_low_ff, same_low, 1'b0)};
      idx_addr(IDX_NEXT_LOW_SECONDARY):
        nxt_hrdata = {24'h00_0000, nd_read(next_low_ff, same_low, 1'b1)};
      idx_addr(IDX_NEXT_HIGH_PRIMARY):
        nxt_hrdata = {24'h00_0000, nd_read(next_high_ff, same_high, 1'b0)};
      idx_addr(IDX_NEXT_HIGH_SECONDARY):
        nxt_hrdata = {24'h00_0000, nd_read(next_high_ff, same_high, 1'b1)};
      default: nxt_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_ff <= '0;
    end
    else if (hready)
    begin
      ap_ff.wr <= take && hwrite;
      ap_ff.addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata_ff <= nxt_hrdata;
  end

  // Zero wait and always OKAY, still launched from flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
    else
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  // ----------------------------------------------------------------
  // Write decode in the data phase
  // ----------------------------------------------------------------
  assign wr_mode_upper = ap_ff.wr && (ap_ff.addr == ADDR_PORT_MODE_UPPER);
  assign wr_mode_lower = ap_ff.wr && (ap_ff.addr == ADDR_PORT_MODE_LOWER);
  assign wr_port_data = ap_ff.wr && (ap_ff.addr == ADDR_PORT_OUTPUT_DATA);
  assign wr_enable = ap_ff.wr && (ap_ff.addr == ADDR_OUTPUT_ENABLE);
  assign wr_trig_sel = ap_ff.wr && (ap_ff.addr == ADDR_TRIGGER_SELECT);
  assign wr_low_pri = ap_ff.wr && (ap_ff.addr == idx_addr(IDX_NEXT_LOW_PRIMARY));
  assign wr_low_sec = ap_ff.wr && (ap_ff.addr == idx_addr(IDX_NEXT_LOW_SECONDARY));
  assign wr_high_pri = ap_ff.wr && (ap_ff.addr == idx_addr(IDX_NEXT_HIGH_PRIMARY));
  assign wr_high_sec = ap_ff.wr && (ap_ff.addr == idx_addr(IDX_NEXT_HIGH_SECONDARY));

  // ----------------------------------------------------------------
  // Port mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_upper_ff <= RST_PORT_MODE;
      mode_lower_ff <= RST_PORT_MODE;
    end
    else
    begin
      if (wr_mode_upper)
        mode_upper_ff <= hwdata[15:0];
      if (wr_mode_lower)
        mode_lower_ff <= hwdata[15:0];
    end
  end

  assign port_mode_upper_pins = mode_upper_ff;
  assign port_mode_lower_pins = mode_lower_ff;

  // ----------------------------------------------------------------
  // Enables and trigger select
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable_ff <= RST_OUTPUT_ENABLE;
      trig_sel_ff <= RST_TRIGGER_SELECT;
    end
    else
    begin
      if (wr_enable)
        enable_ff <= hwdata[15:0];
      if (wr_trig_sel)
        trig_sel_ff <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Next-data registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      next_low_ff <= RST_NEXT_DATA;
      next_high_ff <= RST_NEXT_DATA;
    end
    else
    begin
      if (wr_low_pri || wr_low_sec)
        next_low_ff <= (next_low_ff & ~low_wmask) | (hwdata[7:0] & low_wmask);
      if (wr_high_pri || wr_high_sec)
        next_high_ff <= (next_high_ff & ~high_wmask) | (hwdata[7:0] & high_wmask);
    end
  end

  // ----------------------------------------------------------------
  // Port data: processor writes to free bits, copies to enabled bits
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      port_data_ff <= RST_PORT_DATA;
    else
    begin
      for (int b = 0; b < 16; b++)
      begin
        if (copy_mask[b])
          port_data_ff[b] <= (b < 8) ? next_low_ff[b % 8] : next_high_ff[b % 8];
        else if (wr_port_data && !enable_ff[b])
          port_data_ff[b] <= hwdata[b];
      end
    end
  end

  assign pattern_out_pins = port_data_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mode_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mode_upper |=> port_mode_upper_pins == $past(hwdata[15:0]))
    else $error("Upper port mode write not stored");

  a_pd_free_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_port_data && copy_mask == 16'h0000
    |=> (pattern_out_pins & ~$past(enable_ff)) == ($past(hwdata[15:0]) & ~$past(enable_ff)))
    else $error("Free port data bits not written");

  a_pd_ro_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_port_data && copy_mask == 16'h0000
    |=> (pattern_out_pins & $past(enable_ff)) == ($past(port_data_ff) & $past(enable_ff)))
    else $error("Enabled port data bit changed by write");

  a_copy_low: assert property (@(posedge hclk) disable iff (!hresetn)
    group_fire[0] |=> (pattern_out_pins[3:0] & $past(enable_ff[3:0]))
                      == ($past(next_low_ff[3:0]) & $past(enable_ff[3:0])))
    else $error("Group 0 copy wrong");

  a_copy_high: assert property (@(posedge hclk) disable iff (!hresetn)
    group_fire[3] |=> (pattern_out_pins[15:12] & $past(enable_ff[15:12]))
                      == ($past(next_high_ff[7:4]) & $past(enable_ff[15:12])))
    else $error("Group 3 copy wrong");

  a_no_copy_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !group_fire[1] && !wr_port_data |=> $stable(pattern_out_pins[7:4]))
    else $error("Group 1 changed without trigger or write");

  a_low_same_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_low_pri && same_low && !wr_trig_sel |=> next_low_ff == $past(hwdata[7:0]))
    else $error("Shared low byte write not stored");

  a_low_rsv_read: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr == idx_addr(IDX_NEXT_LOW_SECONDARY) && same_low
    |=> hrdata == 32'h0000_00ff)
    else $error("Reserved low secondary not all ones");

  a_high_split_rd: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr == idx_addr(IDX_NEXT_HIGH_PRIMARY) && !same_high
    |=> hrdata[3:0] == 4'hf && hrdata[7:4] == $past(next_high_ff[7:4]))
    else $error("Split high primary readback wrong");

  a_sel_reset: assert property (@(posedge hclk)
    $rose(hresetn) |-> trig_sel_ff == 8'hff && same_low && same_high)
    else $error("Trigger select not at reset value");

  a_mode_lo_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mode_lower |=> port_mode_lower_pins == $past(hwdata[15:0]))
    else $error("Lower port mode write not stored");

  a_disabled_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_port_data
    |=> (pattern_out_pins & ~$past(enable_ff)) == ($past(port_data_ff) & ~$past(enable_ff)))
    else $error("Disabled port data bit changed without write");

  a_copy_grp1: assert property (@(posedge hclk) disable iff (!hresetn)
    group_fire[1] |=> (pattern_out_pins[7:4] & $past(enable_ff[7:4]))
                      == ($past(next_low_ff[7:4]) & $past(enable_ff[7:4])))
    else $error("Group 1 copy wrong");

  a_copy_grp2: assert property (@(posedge hclk) disable iff (!hresetn)
    group_fire[2] |=> (pattern_out_pins[11:8] & $past(enable_ff[11:8]))
                      == ($past(next_high_ff[3:0]) & $past(enable_ff[11:8])))
    else $error("Group 2 copy wrong");

  a_low_rsv_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_low_sec && same_low |=> $stable(next_low_ff))
    else $error("Reserved low secondary write changed data");

  a_low_split_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_low_sec && !same_low
    |=> next_low_ff == {$past(next_low_ff[7:4]), $past(hwdata[3:0])})
    else $error("Split low group 0 write wrong");

  a_low_split_rd: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr == idx_addr(IDX_NEXT_LOW_SECONDARY) && !same_low
    |=> hrdata[7:4] == 4'hf && hrdata[3:0] == $past(next_low_ff[3:0]))
    else $error("Split low secondary readback wrong");

  a_high_same_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_high_pri && same_high |=> next_high_ff == $past(hwdata[7:0]))
    else $error("Shared high byte write not stored");

  a_high_rsv_rd: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr == idx_addr(IDX_NEXT_HIGH_SECONDARY) && same_high
    |=> hrdata == 32'h0000_00ff)
    else $error("Reserved high secondary not all ones");

  a_high_split_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_high_pri && !same_high
    |=> next_high_ff == {$past(hwdata[7:4]), $past(next_high_ff[3:0])})
    else $error("Split high group 3 write wrong");

  a_nd_reset: assert property (@(posedge hclk)
    $rose(hresetn) |-> next_low_ff == RST_NEXT_DATA && next_high_ff == RST_NEXT_DATA)
    else $error("Next-data registers not at reset value");

endmodule : pond_regs

// *** verification/pond_timer_model.sv ***
/*
  Behavioural stand-in for the timer pulse unit: emits one-cycle
  compare-match pulses on request, promptly or after a chosen delay.
  Assumes the bench raises fire for exactly one cycle per request.
*/
`timescale 1ns/1ps
module pond_timer_model
  import pond_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] fire,
  input wire logic [7:0] delay,
  output logic [3:0] cmp_match
);
  logic [3:0] pend_ff;
  logic [7:0] cnt_ff;

  // One pulse per request, channel bits as asked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_ff <= 4'h0;
      cnt_ff <= 8'h00;
      cmp_match <= 4'h0;
    end
    else if (fire != 4'h0)
    begin
      pend_ff <= fire;
      cnt_ff <= delay;
      cmp_match <= 4'h0;
    end
    else if (pend_ff != 4'h0 && cnt_ff == 8'h00)
    begin
      cmp_match <= pend_ff;
      pend_ff <= 4'h0;
    end
    else
    begin
      cmp_match <= 4'h0;
      cnt_ff <= (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : cnt_ff;
    end
  end
endmodule : pond_timer_model

// *** verification/pond_regs_tb_top.sv ***
/*
  Self-checking bench for the pattern output register bank.
  Assumes the AHB-Lite slave and timer model share one 50 MHz clock.
*/
`timescale 1ns/1ps
module pond_regs_tb_top
  import pond_pkg::*;
;
  localparam logic [31:0] A_HP = {IDX_NEXT_HIGH_PRIMARY[29:0], 2'b00};
  localparam logic [31:0] A_LP = {IDX_NEXT_LOW_PRIMARY[29:0], 2'b00};
  localparam logic [31:0] A_HS = {IDX_NEXT_HIGH_SECONDARY[29:0], 2'b00};
  localparam logic [31:0] A_LS = {IDX_NEXT_LOW_SECONDARY[29:0], 2'b00};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [3:0] cmp_match;
  logic [3:0] fire = 4'h0;
  logic [7:0] dly = 8'h00;
  logic [15:0] pins;
  logic [15:0] mode_up;
  logic [15:0] mode_lo;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;

  assign hready = hreadyout;
  always #10 hclk = ~hclk;

  pond_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cmp_match(cmp_match), .pattern_out_pins(pins),
    .port_mode_upper_pins(mode_up), .port_mode_lower_pins(mode_lo));
  pond_timer_model timer (.hclk(hclk), .hresetn(hresetn), .fire(fire),
    .delay(dly), .cmp_match(cmp_match));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask : chk

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 100);
    if (n >= 100)
      chk("hready wait", 32'h0000_0001, 32'h0000_0000);
  endtask : wait_ready

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ_BIT;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h0000_0000, rd);
    chk(nm, exp, rd);
  endtask : rd_chk

  task automatic match(input logic [3:0] ch, input logic [7:0] d, input logic [15:0] exp);
    fire <= ch;
    dly <= d;
    @(posedge hclk);
    fire <= 4'h0;
    repeat (d + 4) @(posedge hclk);
    chk("pins", {16'h0000, exp}, {16'h0000, pins});
  endtask : match

  task automatic t_reset();
    rd_chk("mode up", ADDR_PORT_MODE_UPPER, 32'h0000_0000);
    rd_chk("mode lo", ADDR_PORT_MODE_LOWER, 32'h0000_0000);
    rd_chk("port data", ADDR_PORT_OUTPUT_DATA, 32'h0000_0000);
    rd_chk("trig sel", ADDR_TRIGGER_SELECT, 32'h0000_00ff);
    rd_chk("low prim", A_LP, 32'h0000_0000);
    rd_chk("high prim", A_HP, 32'h0000_0000);
    chk("pins", 32'h0000_0000, {16'h0000, pins});
    $display("test reset done");
  endtask : t_reset

  task automatic t_mode();
    wr(ADDR_PORT_MODE_UPPER, 32'h0000_ffff);
    wr(ADDR_PORT_MODE_LOWER, 32'h0000_a5a5);
    rd_chk("mode up", ADDR_PORT_MODE_UPPER, 32'h0000_ffff);
    rd_chk("mode lo", ADDR_PORT_MODE_LOWER, 32'h0000_a5a5);
    chk("mode pins", 32'ha5a5_ffff, {mode_lo, mode_up});
    wr(ADDR_PORT_MODE_LOWER, 32'h0000_ffff);
    rd_chk("mode lo", ADDR_PORT_MODE_LOWER, 32'h0000_ffff);
    $display("test mode done");
  endtask : t_mode

  task automatic t_shared();
    wr(A_LP, 32'h0000_005a);
    wr(A_LS, 32'h0000_0000);
    wr(A_HP, 32'h0000_00c3);
    wr(A_HS, 32'h0000_00ff);
    rd_chk("low prim", A_LP, 32'h0000_005a);
    rd_chk("low sec", A_LS, 32'h0000_00ff);
    rd_chk("high prim", A_HP, 32'h0000_00c3);
    rd_chk("high sec", A_HS, 32'h0000_00ff);
    wr(ADDR_OUTPUT_ENABLE, 32'h0000_0f0f);
    rd_chk("enable", ADDR_OUTPUT_ENABLE, 32'h0000_0f0f);
    match(4'h8, 8'h00, 16'h030a);
    wr(ADDR_PORT_OUTPUT_DATA, 32'h0000_ffff);
    rd_chk("port data", ADDR_PORT_OUTPUT_DATA, 32'h0000_f3fa);
    wr(ADDR_OUTPUT_ENABLE, 32'h0000_ffff);
    match(4'h8, 8'h03, 16'hc35a);
    $display("test shared done");
  endtask : t_shared

  task automatic t_split();
    logic [15:0] exp [4];
    exp = '{16'h4796, 16'hc796, 16'hc396, 16'hc356};
    wr(ADDR_TRIGGER_SELECT, 32'h0000_001b);
    rd_chk("trig sel", ADDR_TRIGGER_SELECT, 32'h0000_001b);
    wr(A_LP, 32'h0000_009f);
    wr(A_LS, 32'h0000_00f6);
    wr(A_HP, 32'h0000_004f);
    wr(A_HS, 32'h0000_00f7);
    rd_chk("low prim", A_LP, 32'h0000_009f);
    rd_chk("low sec", A_LS, 32'h0000_00f6);
    rd_chk("high prim", A_HP, 32'h0000_004f);
    rd_chk("high sec", A_HS, 32'h0000_00f7);
    for (int c = 3; c >= 0; c--)
      match(4'h1 << c, 8'(c), exp[c]);
    wr(ADDR_TRIGGER_SELECT, 32'h0000_00ff);
    rd_chk("low prim", A_LP, 32'h0000_0096);
    rd_chk("high prim", A_HP, 32'h0000_0047);
    rd_chk("low sec", A_LS, 32'h0000_00ff);
    $display("test split done");
  endtask : t_split

  task automatic t_misc();
    wr(32'h0000_0020, 32'h0000_1234);
    rd_chk("unmapped", 32'h0000_0020, 32'h0000_0000);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("low prim", A_LP, 32'h0000_0000);
    rd_chk("high prim", A_HP, 32'h0000_0000);
    chk("pins", 32'h0000_0000, {16'h0000, pins});
    $display("test misc done");
  endtask : t_misc

  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_mode();
    t_shared();
    t_split();
    t_misc();
    tally_and_finish();
  end
endmodule : pond_regs_tb_top
